// *** logic/tsrbf_pkg.sv ***
package tsrbf_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_TX_PAIR_B = 12'h057;
  localparam logic [11:0] IDX_RX_FRAMING = 12'h058;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h060;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h061;
  localparam logic [11:0] IDX_RX_INFO = 12'h062;
  localparam logic [11:0] ADDR_TX_PAIR_B = 12'(IDX_TX_PAIR_B * 4);
  localparam logic [11:0] ADDR_RX_FRAMING = 12'(IDX_RX_FRAMING * 4);
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'(IDX_IRQ_STATUS * 4);
  localparam logic [11:0] ADDR_IRQ_MASK = 12'(IDX_IRQ_MASK * 4);
  localparam logic [11:0] ADDR_RX_INFO = 12'(IDX_RX_INFO * 4);
  // Symbol pair B fields
  localparam int TXB_MILLER_BIT = 6;
  localparam int TXB_PULSE_LSB = 4;
  localparam int TXB_INV_BIT = 3;
  localparam int TXB_ENV_LSB = 0;
  localparam logic [7:0] TXB_WMASK = 8'h7F;
  localparam logic [7:0] TXB_RESET = 8'h00;
  // Receive framing fields
  localparam int RXF_INVPAR_BIT = 5;
  localparam int RXF_LENGTH_BIT = 4;
  localparam int RXF_MSB_BIT = 3;
  localparam int RXF_STOPBIT_BIT = 2;
  localparam int RXF_ODD_BIT = 1;
  localparam logic [7:0] RXF_WMASK = 8'h3E;
  localparam logic [7:0] RXF_RESET = 8'h00;
  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FRAME = 1;
  localparam int IRQ_PARITY = 2;
  localparam int IRQ_BYTE = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  // Pulse and envelope codes
  localparam logic [1:0] PULSE_NONE = 2'h0;
  localparam logic [1:0] PULSE_START = 2'h1;
  localparam logic [1:0] PULSE_HALF = 2'h2;
  localparam logic [1:0] PULSE_QTR3 = 2'h3;
  localparam logic [2:0] ENV_DIRECT = 3'h0;
  localparam logic [2:0] ENV_MANCH = 3'h1;
  localparam logic [2:0] ENV_MANCH_SUB = 3'h2;
  localparam logic [2:0] ENV_BPSK = 3'h3;
  localparam logic [2:0] ENV_RZ_SECOND = 3'h4;
  localparam logic [2:0] ENV_RZ_START = 3'h5;
  // Transmit bit timing: a bit is four quarters
  localparam int CLK_NS = 50;
  localparam int TX_BIT_NS = 1600;
  localparam logic [7:0] QTR_CYCLES = 8'(TX_BIT_NS / (4 * CLK_NS));
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
endpackage

// *** logic/tsrbf_link_if.sv ***
`timescale 1ns/10ps
// Settings and strobes shared between the top and its two workers
interface tsrbf_link_if;
  logic qtick;
  logic [1:0] pulse_sel;
  logic miller_en;
  logic invert;
  logic [2:0] env_sel;
  logic rx_bit;
  logic rx_shift;
  logic rx_clear;
  logic high_first;
  logic [7:0] rx_data;
  logic rx_parity;
  modport top (output qtick, pulse_sel, miller_en, invert, env_sel, rx_bit, rx_shift, rx_clear, high_first,
               input rx_data, rx_parity);
  modport tx (input qtick, pulse_sel, miller_en, invert, env_sel);
  modport rx (input rx_bit, rx_shift, rx_clear, high_first, output rx_data, rx_parity);
endinterface

// *** logic/tsrbf_tx_shaper.sv ***
`timescale 1ns/10ps
module tsrbf_tx_shaper
  import tsrbf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  tsrbf_link_if.tx lk,
  input wire logic tx_bit,
  input wire logic tx_pair_b,
  output logic tx_out,
  output logic tx_bit_take
);
  logic [1:0] q_r;
  logic cur_r;
  logic prev_r;
  logic pair_r;
  wire new_bit = lk.qtick && (q_r == 2'h3);
  wire env_lvl;
  wire pulse_hit;
  wire shaped;

  // Envelope level for one quarter of a bit
  function automatic logic env_level(input logic [2:0] env, input logic b, input logic [1:0] q);
    unique case (env)
      ENV_DIRECT: env_level = b;
      ENV_MANCH: env_level = b ? ~q[1] : q[1];
      ENV_MANCH_SUB: env_level = (b ? ~q[1] : q[1]) & q[0];
      ENV_BPSK: env_level = b ^ q[0];
      ENV_RZ_SECOND: env_level = b & q[1];
      ENV_RZ_START: env_level = b & ~q[1];
      default: env_level = 1'b0; // Reserved codes send nothing
    endcase
  endfunction

  // Pulse position; Miller drops the start pulse of a zero after a one
  function automatic logic pulse_at(input logic [1:0] sel, input logic mil, input logic b, input logic pb,
                                    input logic [1:0] q);
    if (mil && sel == PULSE_START)
      pulse_at = b ? (q == 2'h2) : (q == 2'h0 && !pb); // RL2
    else
      unique case (sel)
        PULSE_START: pulse_at = b && q == 2'h0;
        PULSE_HALF: pulse_at = b && q == 2'h2;
        PULSE_QTR3: pulse_at = b && q == 2'h3;
        default: pulse_at = 1'b0;
      endcase
  endfunction

  assign env_lvl = env_level(lk.env_sel, cur_r, q_r); // RL5
  assign pulse_hit = pulse_at(lk.pulse_sel, lk.miller_en, cur_r, prev_r, q_r); // RL1
  // Pulse mode overrides the envelope; pair A goes out unshaped
  assign shaped = (lk.pulse_sel != PULSE_NONE) ? pulse_hit : env_lvl;

  // Quarter counter and bit capture at the bit boundary
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q_r <= 2'h0;
      cur_r <= 1'b0;
      prev_r <= 1'b0;
      pair_r <= 1'b0;
      tx_out <= 1'b0;
      tx_bit_take <= 1'b0;
    end
    else
    begin
      if (lk.qtick)
        q_r <= q_r + 2'h1;
      if (new_bit)
      begin
        prev_r <= cur_r;
        cur_r <= tx_bit;
        pair_r <= tx_pair_b;
      end
      tx_bit_take <= new_bit;
      tx_out <= pair_r ? (shaped ^ lk.invert) : cur_r; // RL4
    end
  end
endmodule

// *** logic/tsrbf_rx_shifter.sv ***
`timescale 1ns/10ps
module tsrbf_rx_shifter
  import tsrbf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  tsrbf_link_if.rx lk
);
  // Byte assembly in the chosen order, running parity beside it
  always_ff @(posedge clk)
  begin
    if (reset || lk.rx_clear)
    begin
      lk.rx_data <= 8'h00;
      lk.rx_parity <= 1'b0;
    end
    else if (lk.rx_shift)
    begin
      if (lk.high_first)
        lk.rx_data <= {lk.rx_data[6:0], lk.rx_bit}; // RL8
      else
        lk.rx_data <= {lk.rx_bit, lk.rx_data[7:1]}; // RL8
      lk.rx_parity <= lk.rx_parity ^ lk.rx_bit;
    end
  end
endmodule

// *** logic/tsrbf_top.sv ***
`timescale 1ns/10ps
// Behaviour
// RL1 - Pulse type picks pulse position for pair B
// RL2 - Miller bit applies modified Miller pulse coding
// RL3 - Software sets Miller only with pulse type 1
// RL4 - Inversion bit inverts third and fourth symbols
// RL5 - Envelope field shapes bit stream, six codes
// RL6 - Inverse parity ends reception when enabled
// RL7 - First byte gives length; stop when reached
// RL8 - Bit order control sets byte assembly order
// RL9 - Stop bit expected, checked and removed
// RL10 - Good stop bit resets the demodulator
// RL11 - Bad stop bit flags error, aborts reception
// RL12 - A valid stop bit is always one
// RL13 - Parity type: clear even, set odd
// RL14 - First enabled stop condition ends reception
module tsrbf_top
  import tsrbf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic tx_bit,
  input wire logic tx_pair_b,
  output logic tx_out,
  output logic tx_bit_take,
  input wire logic rx_start,
  input wire logic rx_end,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  output logic rx_active,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic demod_reset,
  output logic rx_frame_error
);
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_DATA = 4'b0010,
    RX_PAR = 4'b0100,
    RX_STOP = 4'b1000
  } tsrbf_rx_state_t;

  tsrbf_link_if lk ();

  logic [7:0] txb_r;
  logic [7:0] rxf_r;
  logic [IRQ_W-1:0] status_r;
  logic [IRQ_W-1:0] status_nxt;
  logic [IRQ_W-1:0] mask_r;
  logic [7:0] qdiv_r;
  logic qtick_r;
  tsrbf_rx_state_t state_r;
  tsrbf_rx_state_t state_nxt;
  logic [2:0] bitcnt_r;
  logic [7:0] count_r;
  logic [7:0] length_r;
  logic [IRQ_W-1:0] events;

  // APB decode
  wire access = psel && penable && !pready;
  // Writes land at the edge where pready is sampled high
  wire wr = psel && penable && pready && pwrite;
  wire rd = access && !pwrite;
  wire hit_txb = paddr == ADDR_TX_PAIR_B;
  wire hit_rxf = paddr == ADDR_RX_FRAMING;
  wire hit_st = paddr == ADDR_IRQ_STATUS;
  wire hit_mask = paddr == ADDR_IRQ_MASK;
  wire hit_info = paddr == ADDR_RX_INFO;
  wire mapped = hit_txb || hit_rxf || hit_st || hit_mask || hit_info;
  wire status_clr = rd && hit_st;

  // Receive controls from the framing register
  wire halt_invpar = rxf_r[RXF_INVPAR_BIT];
  wire halt_length = rxf_r[RXF_LENGTH_BIT];
  wire stop_chk = rxf_r[RXF_STOPBIT_BIT];
  wire parity_odd = rxf_r[RXF_ODD_BIT];

  // Bit event qualifiers
  wire in_frame = state_r != RX_IDLE;
  wire take_bit = rx_bit_valid && in_frame && !rx_end;
  wire data_bit = take_bit && state_r == RX_DATA;
  wire par_bit = take_bit && state_r == RX_PAR;
  wire stop_seen = take_bit && state_r == RX_STOP;

  // Parity of data plus parity bit must equal the odd flag
  wire parity_bad = (lk.rx_parity ^ rx_bit) != parity_odd; // RL13
  wire [7:0] count_inc = count_r + 8'h01;
  wire [7:0] frame_len = (count_r == 8'h00) ? lk.rx_data : length_r;
  wire len_reached = halt_length && (count_inc >= frame_len); // RL7
  wire invpar_stop = halt_invpar && parity_bad; // RL6
  wire char_ends = len_reached || invpar_stop; // RL14
  wire stop_good = stop_seen && rx_bit; // RL12
  wire stop_bad = stop_seen && !rx_bit; // RL11
  wire frame_ends = (in_frame && rx_end) || (par_bit && char_ends); // RL14

  // Zero-extend a register into a bus word
  function automatic logic [31:0] word_of_byte(input logic [7:0] v);
    word_of_byte = {24'h000000, v};
  endfunction

  function automatic logic [31:0] word_of_irq(input logic [IRQ_W-1:0] v);
    word_of_irq = {{(32-IRQ_W){1'b0}}, v};
  endfunction

  // Byte read-back: last byte, count, activity
  wire [31:0] info_word = {15'h0000, in_frame, count_r, rx_byte};
  wire [31:0] rdata_mux = hit_txb ? word_of_byte(txb_r)
                        : hit_rxf ? word_of_byte(rxf_r)
                        : hit_st ? word_of_irq(status_r)
                        : hit_mask ? word_of_irq(mask_r)
                        : hit_info ? info_word
                        : 32'h00000000;

  // Settings handed to the workers
  assign lk.qtick = qtick_r;
  assign lk.pulse_sel = txb_r[TXB_PULSE_LSB +: 2]; // RL1
  // Software keeps the Miller bit to pulse type 1; the shaper ignores it otherwise
  assign lk.miller_en = txb_r[TXB_MILLER_BIT]; // RL3
  assign lk.invert = txb_r[TXB_INV_BIT];
  assign lk.env_sel = txb_r[TXB_ENV_LSB +: 3];
  assign lk.high_first = rxf_r[RXF_MSB_BIT];
  assign lk.rx_bit = rx_bit;
  assign lk.rx_shift = data_bit;
  // Fresh character at frame start and after each parity bit
  assign lk.rx_clear = (rx_start && !in_frame) || par_bit;

  // Events that feed the sticky status
  assign events[IRQ_DONE] = frame_ends;
  assign events[IRQ_FRAME] = stop_chk && stop_bad; // RL11
  assign events[IRQ_PARITY] = par_bit && parity_bad && !halt_invpar;
  assign events[IRQ_BYTE] = par_bit;

  // Set wins over the read clear
  assign status_nxt = (status_clr ? IRQ_RESET : status_r) | events;

  // Receive sequencing
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      RX_IDLE:
        if (rx_start)
          state_nxt = RX_DATA;
      RX_DATA:
        if (rx_end)
          state_nxt = RX_IDLE;
        else if (data_bit && bitcnt_r == LAST_DATA_BIT)
          state_nxt = RX_PAR;
      RX_PAR:
        if (frame_ends)
          state_nxt = RX_IDLE;
        else if (par_bit)
          state_nxt = stop_chk ? RX_STOP : RX_DATA; // RL9
      RX_STOP:
        if (rx_end || stop_bad)
          state_nxt = RX_IDLE; // RL11
        else if (stop_good)
          state_nxt = RX_DATA; // RL9
    endcase
  end

  // Divider end count, shared by the counter and the tick
  wire qdiv_wrap = qdiv_r == QTR_CYCLES - 8'h01;

  // Quarter-bit divider for the transmit shaper
  always_ff @(posedge clk)
  begin
    if (reset || qdiv_wrap)
      qdiv_r <= 8'h00;
    else
      qdiv_r <= qdiv_r + 8'h01;
  end

  // Registered strobe keeps the tick free of glitches
  always_ff @(posedge clk)
  begin
    if (reset)
      qtick_r <= 1'b0;
    else
      qtick_r <= qdiv_wrap;
  end

  // APB answer: one wait state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= access;
      pslverr <= access && !mapped;
    end
  end

  // Read data held until the next read
  always_ff @(posedge clk)
  begin
    if (reset)
      prdata <= 32'h00000000;
    else if (rd)
      prdata <= rdata_mux;
  end

  // Pair B modulation; reserved bit stays zero
  always_ff @(posedge clk)
  begin
    if (reset)
      txb_r <= TXB_RESET;
    else if (wr && hit_txb)
      txb_r <= pwdata[7:0] & TXB_WMASK;
  end

  // Receive framing; reserved bits stay zero
  always_ff @(posedge clk)
  begin
    if (reset)
      rxf_r <= RXF_RESET;
    else if (wr && hit_rxf)
      rxf_r <= pwdata[7:0] & RXF_WMASK;
  end

  // Interrupt mask
  always_ff @(posedge clk)
  begin
    if (reset)
      mask_r <= IRQ_RESET;
    else if (wr && hit_mask)
      mask_r <= pwdata[IRQ_W-1:0];
  end

  // Sticky status
  always_ff @(posedge clk)
  begin
    if (reset)
      status_r <= IRQ_RESET;
    else
      status_r <= status_nxt;
  end

  // Level interrupt, same edge as the status it reflects
  always_ff @(posedge clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(status_nxt & mask_r);
  end

  // Receive state and counters
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= RX_IDLE;
      bitcnt_r <= 3'h0;
      count_r <= 8'h00;
      length_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      if (rx_start && !in_frame)
      begin
        bitcnt_r <= 3'h0;
        count_r <= 8'h00;
      end
      else if (data_bit)
        bitcnt_r <= bitcnt_r + 3'h1;
      if (par_bit)
      begin
        count_r <= count_inc;
        if (count_r == 8'h00)
          length_r <= lk.rx_data; // RL7
      end
    end
  end

  // Byte strobe and activity; the stop bit never reaches the byte
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_byte_valid <= 1'b0;
      rx_active <= 1'b0;
    end
    else
    begin
      rx_byte_valid <= par_bit; // RL9
      rx_active <= state_nxt != RX_IDLE;
    end
  end

  // Last delivered byte, held for the info word
  always_ff @(posedge clk)
  begin
    if (reset)
      rx_byte <= 8'h00;
    else if (par_bit)
      rx_byte <= lk.rx_data;
  end

  // Demodulator resync strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      demod_reset <= 1'b0;
    else
      demod_reset <= stop_good; // RL10
  end

  // Frame error strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      rx_frame_error <= 1'b0;
    else
      rx_frame_error <= stop_bad; // RL11
  end

  tsrbf_tx_shaper u_tx (
    .clk(clk),
    .reset(reset),
    .lk(lk.tx),
    .tx_bit(tx_bit),
    .tx_pair_b(tx_pair_b),
    .tx_out(tx_out),
    .tx_bit_take(tx_bit_take)
  );

  tsrbf_rx_shifter u_rx (
    .clk(clk),
    .reset(reset),
    .lk(lk.rx)
  );
endmodule

// *** test/tsrbf_chk_sva.sv ***
`timescale 1ns/10ps
module tsrbf_chk
  import tsrbf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_bit_take,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic rx_active,
  input wire logic rx_byte_valid,
  input wire logic demod_reset,
  input wire logic rx_frame_error
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Decode of the five mapped words
  wire mapped = paddr inside {ADDR_TX_PAIR_B, ADDR_RX_FRAMING, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_RX_INFO};

  // Bus answer timing and refusal
  a_answer_next: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_unmapped_err: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_unmapped_zero: assert property (pready && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");

  // Bit pacing: four quarters of eight clocks each
  a_take_period: assert property (tx_bit_take |-> ##32 tx_bit_take)
    else $error("bit period not 32 cycles");
  a_take_single: assert property (tx_bit_take |=> (!tx_bit_take) [*8])
    else $error("take pulse repeated");

  // Stop bit handling follows the strobed bit value
  a_resync_good: assert property (demod_reset |-> $past(rx_bit_valid) && $past(rx_bit) && !rx_frame_error)
    else $error("demodulator reset without good stop bit");
  a_ferr_bad: assert property (rx_frame_error |-> $past(rx_bit_valid) && !$past(rx_bit))
    else $error("frame error without bad stop bit");
  a_ferr_abort: assert property (rx_frame_error |-> ##[0:1] !rx_active)
    else $error("frame not aborted");
  a_byte_cause: assert property (rx_byte_valid |-> $past(rx_bit_valid) && $past(rx_active))
    else $error("byte delivered without parity strobe");

  cover property (demod_reset);
  cover property (rx_frame_error);
  cover property (pready && pslverr);
endmodule

// *** test/tsrbf_card_model.sv ***
`timescale 1ns/10ps
module tsrbf_card_model
(
  input wire logic clk,
  input wire logic tx_bit_take,
  output logic tx_bit,
  output logic rx_bit,
  output logic rx_bit_valid
);
  int seed = 32'h3c005f5e;
  logic sent_bit = 1'b0;

  initial
  begin
    tx_bit = 1'b0;
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
  end

  // Next bit offered only after the current one is taken
  always @(posedge clk)
    if (tx_bit_take === 1'b1)
    begin
      sent_bit <= tx_bit;
      tx_bit <= 1'($random(seed));
    end

  // One strobed bit; the line shows the inverse between strobes
  task sb(input logic b);
    repeat (1 + $unsigned($random(seed)) % 3) @(posedge clk);
    rx_bit <= b;
    rx_bit_valid <= 1'b1;
    @(posedge clk);
    rx_bit <= ~b;
    rx_bit_valid <= 1'b0;
  endtask

  // Character: eight data bits, parity, optional stop bit
  task send_char(input logic [7:0] d, input logic par, stop_en, stop_v, msb);
    for (int i = 0; i < 8; i++)
      sb(msb ? d[7 - i] : d[i]);
    sb(par);
    if (stop_en)
      sb(stop_v);
  endtask
endmodule

// *** test/tx_symbol_mod_rx_bit_framing_tb.sv ***
`timescale 1ns/10ps
module tx_symbol_mod_rx_bit_framing_tb
  import tsrbf_pkg::*;
;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, tx_pair_b = 0, rx_start = 0, rx_end = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, tx_out, tx_bit_take, tx_bit, rx_bit, rx_bit_valid;
  logic rx_active, rx_byte_valid, demod_reset, rx_frame_error;
  logic [7:0] rx_byte, lastb, exp_b[8];
  logic [11:0] regs[5] = '{ADDR_TX_PAIR_B, ADDR_RX_FRAMING, ADDR_IRQ_MASK, ADDR_IRQ_STATUS, ADDR_RX_INFO};
  logic [31:0] wm[3] = '{32'(TXB_WMASK), 32'(RXF_WMASK), 32'hF};
  int n_errors = 0, comparisons = 0, nb = 0, ndr = 0, seed = 32'h3c005f5e;

  tsrbf_top dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .tx_bit(tx_bit),
    .tx_pair_b(tx_pair_b), .tx_out(tx_out), .tx_bit_take(tx_bit_take), .rx_start(rx_start), .rx_end(rx_end),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_active(rx_active), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .demod_reset(demod_reset), .rx_frame_error(rx_frame_error));
  tsrbf_card_model partner_u (.clk(clk), .tx_bit_take(tx_bit_take), .tx_bit(tx_bit), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid));

  initial
    forever #25 clk = ~clk;

  task conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bus cycle; the master waits for the slave's own answer
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Expected output level in quarter q of a bit
  function logic exp_tx(input logic b, p, pb, input logic [7:0] c, input int q);
    logic v;
    case (c[5:4])
      PULSE_NONE:
        case (c[2:0])
          ENV_DIRECT: v = b;
          ENV_MANCH: v = b ^ (q > 1);
          ENV_MANCH_SUB: v = (b ^ (q > 1)) & q[0];
          ENV_BPSK: v = b ^ q[0];
          ENV_RZ_SECOND: v = b & (q > 1);
          ENV_RZ_START: v = b & (q < 2);
          default: v = 1'b0;
        endcase
      PULSE_START: v = c[6] ? (b ? q == 2 : q == 0 && !p) : b && q == 0;
      PULSE_HALF: v = b && q == 2;
      default: v = b && q == 3;
    endcase
    return pb ? v ^ c[3] : b;
  endfunction

  // Settle two bits after a change, then check four quarters of five bits
  task tx_run(input logic [7:0] c, input logic pb);
    logic b, p;
    apb(1, ADDR_TX_PAIR_B, 32'(c), rd, err);
    tx_pair_b <= pb;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk);
      while (tx_bit_take !== 1'b1) @(posedge clk);
      b = partner_u.tx_bit;
      p = partner_u.sent_bit;
      repeat (4) @(posedge clk);
      for (int q = 0; q < 4; q++)
      begin
        if (i > 1) chk("tx_out", tx_out, exp_tx(b, p, pb, c, q));
        if (q < 3) repeat (8) @(posedge clk);
      end
    end
  endtask

  // One received frame with optional inverse parity and bad stop bit
  task run_rx(input logic [7:0] cfg, b0, input int n, iv, bad, en, edr, input logic [3:0] est);
    logic [3:0] m;
    logic [7:0] d;
    m = 4'($random(seed));
    cfg = cfg | (8'($random(seed)) & 8'h0A);
    apb(1, ADDR_RX_FRAMING, 32'(cfg), rd, err);
    apb(1, ADDR_IRQ_MASK, 32'(m), rd, err);
    apb(0, ADDR_IRQ_STATUS, 32'h0, rd, err);
    nb = 0;
    ndr = 0;
    @(posedge clk) rx_start <= 1;
    @(posedge clk) rx_start <= 0;
    for (int i = 0; i < n; i++)
    begin
      d = (i == 0) ? b0 : 8'($random(seed));
      exp_b[i] = d;
      partner_u.send_char(d, ^d ^ cfg[RXF_ODD_BIT] ^ (i == iv), cfg[RXF_STOPBIT_BIT], i != bad, cfg[RXF_MSB_BIT]);
    end
    repeat (4) @(posedge clk);
    @(posedge clk) rx_end <= 1;
    @(posedge clk) rx_end <= 0;
    repeat (2) @(posedge clk);
    chk("rx_active", rx_active, 32'h0);
    chk("byte count", nb, en);
    chk("last byte", lastb, exp_b[en - 1]);
    chk("demod resets", ndr, edr);
    chk("irq", irq, |(est & m));
    apb(0, ADDR_IRQ_STATUS, 32'h0, rd, err);
    chk("status", rd, est);
    @(posedge clk);
    chk("irq cleared", irq, 32'h0);
  endtask

  // Received byte and resync pulse monitor
  always @(posedge clk)
  begin
    if (rx_byte_valid === 1'b1) nb++;
    if (rx_byte_valid === 1'b1) lastb = rx_byte;
    if (demod_reset === 1'b1) ndr++;
  end

  initial
  begin
    logic [7:0] c;
    logic [31:0] wd;
    repeat (8) @(posedge clk);
    reset <= 0;
    for (int i = 0; i < 5; i++)
    begin
      apb(0, regs[i], 32'h0, rd, err);
      chk("reset value", rd, 32'h0);
    end
    for (int i = 0; i < 3; i++)
    begin
      wd = $random(seed);
      apb(1, regs[i], wd, rd, err);
      apb(0, regs[i], 32'h0, rd, err);
      chk("readback", rd, wd & wm[i]);
    end
    apb(0, 12'hFFC, 32'h0, rd, err);
    chk("unmapped err", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("Test registers done");
    for (int k = 0; k < 13; k++)
    begin
      c = 8'(k < 8 ? k : (k == 11 ? 8'h50 : (k - 7) << 4));
      if (k < 6 || k > 7) c[3] = 1'($random(seed));
      tx_run(c, k != 12);
    end
    $display("Test transmit done");
    run_rx(8'h04, 8'($random(seed)), 4, 9, 9, 4, 4, 4'h9);
    run_rx(8'h04, 8'($random(seed)), 4, 9, 1, 2, 1, 4'hA);
    run_rx(8'h24, 8'($random(seed)), 4, 2, 9, 3, 2, 4'h9);
    run_rx(8'h00, 8'($random(seed)), 4, 2, 9, 4, 0, 4'hD);
    run_rx(8'h14, 8'h03, 5, 9, 9, 3, 2, 4'h9);
    run_rx(8'h34, 8'h04, 5, 1, 9, 2, 1, 4'h9);
    $display("Test receive done");
    conclude;
  end

  // Hang guard well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude;
  end
endmodule

bind tsrbf_top tsrbf_chk chk_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_bit_take(tx_bit_take), .rx_bit(rx_bit),
  .rx_bit_valid(rx_bit_valid), .rx_active(rx_active), .rx_byte_valid(rx_byte_valid), .demod_reset(demod_reset),
  .rx_frame_error(rx_frame_error));
